/* verilog/cac_central_arbiter.sv */
// Central arbiter: cycle timing, time-out monitor, preempt generator
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/100ps
module cac_central_arbiter
  import cac_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int CPU_MHZ = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] priority_level_value,
  input wire logic cmd_n,
  input wire logic burst_n,
  input wire logic floppy_dma_request,
  input wire logic irq_active,
  input wire logic nmi_request,
  input wire logic chan2_masked,
  input wire logic dma_master_clear,
  input wire logic refresh_done,
  output logic arb_gnt,
  output logic preempt_n,
  output logic nmi,
  output logic dma_reset,
  output logic refresh_active,
  output logic cpu_cycles_en
);

  localparam int SYNC_W = 9;
  localparam int CNT_W = 10;
  localparam logic [CNT_W-1:0] NORM_C = CNT_W'(ARB_NORM_CYC);
  localparam logic [CNT_W-1:0] SLOW_C = CNT_W'(ARB_SLOW_CYC);
  localparam logic [CNT_W-1:0] EXT_C = CNT_W'(ARB_EXT_CYC);
  localparam logic [CNT_W-1:0] MIN_C = CNT_W'(ARB_MIN_CYC);
  localparam logic [CNT_W-1:0] REF_C = CNT_W'(REFRESH_CYC);
  localparam logic [CNT_W-1:0] ONE_C = 10'h001;

  //////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  wire [SYNC_W-1:0] pins_in = {priority_level_value, cmd_n, burst_n,
                               floppy_dma_request, irq_active, nmi_request};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Idle levels, so the bus looks quiet and no false edge follows reset
      sync1 <= PIN_IDLE;
      sync2 <= PIN_IDLE;
    end else begin
      sync1 <= pins_in;
      sync2 <= sync1;
    end
  end

  wire [3:0] level = sync2[8:5];
  wire cmd_act = ~sync2[4];
  wire burst_act = ~sync2[3];
  wire drq_s = sync2[2];
  wire irq_s = sync2[1];
  wire nmi_req_s = sync2[0];

  //////////////////////////////////////////////////////////////////////
  // APB slave, one wait state
  logic [7:0] ctrl;
  logic tout;
  logic [3:0] cap_level;
  wire hit = (paddr == ADDR_W'(ARB_CTRL_OFF));
  wire acc = psel & penable;
  wire take = acc & pready;
  wire wr = take & pwrite & hit;
  wire [7:0] rd_val = {ctrl[BIT_CPU_EN], ctrl[BIT_NMI], tout,
                       ctrl[BIT_IRQ_EN], cap_level};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= acc & ~pready;
      pslverr <= acc & ~pready & ~hit;
      prdata <= (acc & ~pready & hit) ? {24'h000000, rd_val} : 32'h00000000;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Refresh timer and time-out monitor
  cac_state_t state;
  cac_state_t next_state;
  logic [CNT_W-1:0] ref_cnt;
  logic ref_pend;
  wire ref_tick = (ref_cnt == REF_C - ONE_C);
  // Timer period drives the monitor
  wire armed = ref_pend & (state != CAC_REFRESH);
  wire tout_ev = armed & ref_tick;
  wire ref_start = (state == CAC_ARB) & ref_pend;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_cnt <= '0;
      ref_pend <= 1'b0;
    end else begin
      ref_cnt <= ref_tick ? '0 : ref_cnt + ONE_C;
      // A new request wins over service in the same cycle
      if (ref_tick) begin
        ref_pend <= 1'b1;
      end else if (ref_start) begin
        ref_pend <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Control register; hardware sets win over a software clear
  wire nmi_ev = tout_ev | nmi_req_s;
  wire clr6 = wr & ~pwdata[BIT_NMI];
  wire set6 = nmi_ev | (wr & pwdata[BIT_NMI]);
  // Output follows the bit's next value so it drops with the clearing write
  wire next_nmi = set6 | (ctrl[BIT_NMI] & ~clr6);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= ARB_CTRL_RST;
      tout <= 1'b0;
      cap_level <= LVL_ZERO;
    end else begin
      if (wr) begin
        ctrl[BIT_CPU_EN] <= pwdata[BIT_CPU_EN];
        ctrl[BIT_EXT] <= pwdata[BIT_EXT];
        ctrl[BIT_IRQ_EN] <= pwdata[BIT_IRQ_EN];
        ctrl[3:0] <= 4'h0;
      end
      if (set6) begin
        ctrl[BIT_NMI] <= 1'b1;
      end else if (clr6) begin
        ctrl[BIT_NMI] <= 1'b0;
      end
      if (tout_ev) begin
        tout <= 1'b1;
        cap_level <= level;
      end else if (clr6) begin
        tout <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Arbitration cycle sequencer
  logic [CNT_W-1:0] arb_cnt;
  logic [3:0] owner;
  logic owner_master;
  logic fl_pre;
  logic drq_d;
  logic xfer_seen;
  wire [CNT_W-1:0] dflt_c = (CPU_MHZ == SLOW_CPU_MHZ) ? SLOW_C : NORM_C;
  wire [CNT_W-1:0] dur_c = ctrl[BIT_EXT] ? EXT_C : dflt_c;
  wire early = (level == LVL_ZERO) & (arb_cnt >= MIN_C);
  wire done_t = (arb_cnt >= dur_c) | early;
  // NMI flag and pending refresh hold the line at arbitration
  wire hold = ctrl[BIT_NMI] | ref_pend;
  wire arb_end = (state == CAC_ARB) & done_t & ~hold;
  wire not_sys = (level != LVL_SYSTEM);
  wire in_gnt = (state == CAC_GNT);
  // A granted master must run a transfer and go quiet before it gives way to a preempt
  wire owner_busy = owner_master & (~xfer_seen | cmd_act | burst_act);
  wire idle = in_gnt & owner_master & xfer_seen & ~cmd_act & ~burst_act;
  wire pre_ref = in_gnt & ref_pend;
  wire pre_nmi = in_gnt & ctrl[BIT_NMI] & not_sys;
  wire pre_irq = in_gnt & not_sys & ctrl[BIT_IRQ_EN] & irq_s;
  wire pre_any = fl_pre | pre_ref | pre_nmi | pre_irq;
  // A master that never lets go is only freed by an NMI event: the time-out or the NMI request pin
  wire start = in_gnt & ((pre_any & ~owner_busy) | idle | nmi_ev);

  always_comb begin
    next_state = state;
    case (state)
      CAC_GNT: begin
        if (start) begin
          next_state = CAC_ARB;
        end
      end
      CAC_ARB: begin
        if (ref_start) begin
          next_state = CAC_REFRESH;
        end else if (arb_end) begin
          next_state = CAC_GNT;
        end
      end
      CAC_REFRESH: begin
        if (refresh_done) begin
          next_state = CAC_ARB;
        end
      end
      default: begin
        next_state = CAC_GNT;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= CAC_GNT;
      arb_cnt <= '0;
      owner <= LVL_SYSTEM;
      owner_master <= 1'b0;
    end else begin
      state <= next_state;
      // Counter keeps running through refresh so time only grows
      if (state == CAC_GNT) begin
        arb_cnt <= '0;
      end else if (arb_cnt != {CNT_W{1'b1}}) begin
        arb_cnt <= arb_cnt + ONE_C;
      end
      if (arb_end) begin
        owner <= level;
        owner_master <= not_sys;
      end
    end
  end

  // Bus activity seen since this grant began; cleared while arbitrating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_seen <= 1'b0;
    end else begin
      xfer_seen <= in_gnt & (xfer_seen | cmd_act | burst_act);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Floppy preempt source; a fresh request wins over a clear
  wire fl_set = drq_s & ~drq_d & ~chan2_masked;
  wire fl_win = arb_end & (level == LVL_FLOPPY);
  wire fl_clr = dma_master_clear | fl_win;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drq_d <= 1'b0;
      fl_pre <= 1'b0;
    end else begin
      drq_d <= drq_s;
      if (fl_set) begin
        fl_pre <= 1'b1;
      end else if (fl_clr) begin
        fl_pre <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Registered outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arb_gnt <= 1'b0;
      preempt_n <= 1'b1;
      nmi <= 1'b0;
      dma_reset <= 1'b0;
      refresh_active <= 1'b0;
      cpu_cycles_en <= 1'b0;
    end else begin
      arb_gnt <= (next_state != CAC_GNT);
      preempt_n <= ~pre_any;
      nmi <= next_nmi;
      dma_reset <= tout_ev;
      refresh_active <= (next_state == CAC_REFRESH);
      cpu_cycles_en <= ctrl[BIT_CPU_EN];
    end
  end

  // Owner value is not used by any decode; level itself is not driven here
  wire unused_owner = ^owner;

endmodule

/* verilog/cac_pkg.sv */
// Package: constants for the central arbitration control block
package cac_pkg;
  // Clock and timing
  localparam int CLK_PS = 25000;
  localparam int ARB_NORM_NS = 300;
  localparam int ARB_SLOW_NS_X10 = 3125;
  localparam int ARB_EXT_NS = 750;
  localparam int ARB_MIN_NS = 100;
  localparam int REFRESH_US = 15;
  localparam int SLOW_CPU_MHZ = 16;

  // Least time in picoseconds to whole cycles, at least one
  function automatic int ps_to_cyc(input int ps);
    int c;
    c = (ps + CLK_PS - 1) / CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int ARB_NORM_CYC = ps_to_cyc(ARB_NORM_NS * 1000);
  localparam int ARB_SLOW_CYC = ps_to_cyc(ARB_SLOW_NS_X10 * 100);
  localparam int ARB_EXT_CYC = ps_to_cyc(ARB_EXT_NS * 1000);
  localparam int ARB_MIN_CYC = ps_to_cyc(ARB_MIN_NS * 1000);
  // Approximate period, rounded down
  localparam int REFRESH_CYC = (REFRESH_US * 1000000) / CLK_PS;

  // Register map
  localparam logic [11:0] ARB_CTRL_OFF = 12'h090;
  localparam logic [7:0] ARB_CTRL_RST = 8'h00;
  localparam int BIT_CPU_EN = 7;
  localparam int BIT_NMI = 6;
  localparam int BIT_TOUT = 5;
  localparam int BIT_EXT = 5;
  localparam int BIT_IRQ_EN = 4;

  // Arbitration levels
  localparam logic [3:0] LVL_SYSTEM = 4'hf;
  localparam logic [3:0] LVL_ZERO = 4'h0;
  localparam logic [3:0] LVL_FLOPPY = 4'h2;
  // Pin levels held in the synchronisers during reset: system level, strobes idle
  localparam logic [8:0] PIN_IDLE = 9'h1f8;

  typedef enum logic [1:0] {
    CAC_GNT,
    CAC_ARB,
    CAC_REFRESH
  } cac_state_t;
endpackage

/* tb/cac_central_arbiter_asserts.sv */
// Checker: bus handshake, arbitration hold and time-out properties
`timescale 1ns/100ps
module cac_central_arbiter_asserts
  import cac_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic arb_gnt,
  input wire logic nmi,
  input wire logic dma_reset
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire clr_nmi = psel && penable && pready && pwrite && paddr == ARB_CTRL_OFF && !pwdata[BIT_NMI];
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable;
  endsequence
  chk_one_wait: assert property (setup_s ##1 access_s |-> !pready ##1 pready)
    else $error("pready late");
  chk_rdy_pulse: assert property (pready |=> !pready)
    else $error("pready too long");
  chk_bad_addr: assert property (pready && paddr != ARB_CTRL_OFF |-> pslverr)
    else $error("no slave error");
  chk_nmi_stays: assert property (nmi && !clr_nmi |=> nmi)
    else $error("nmi dropped");
  chk_arb_held: assert property (nmi && arb_gnt |=> arb_gnt || !nmi)
    else $error("arbitration left early");
  chk_dma_pulse: assert property (dma_reset |=> !dma_reset)
    else $error("dma reset too long");
  chk_tout_nmi: assert property (dma_reset |-> ##[0:1] nmi)
    else $error("time-out without nmi");
  chk_arb_min: assert property ($rose(arb_gnt) |-> arb_gnt [*4])
    else $error("arbitration too short");
endmodule
bind cac_central_arbiter cac_central_arbiter_asserts #(.ADDR_W(ADDR_W)) chk_u (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .arb_gnt(arb_gnt), .nmi(nmi), .dma_reset(dma_reset)
);

/* tb/cac_masters.sv */
// Partner: competing masters and their local arbiters
`timescale 1ns/100ps
module cac_masters (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic arb_gnt,
  input wire logic [3:0] win,
  input wire logic stuck,
  output logic [3:0] level,
  output logic cmd_n
);
  logic [2:0] busy;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level <= 4'hf;
      cmd_n <= 1'b1;
      busy <= 3'h0;
    end else if (arb_gnt) begin
      // Winner drives its level one cycle into arbitration
      level <= win;
      cmd_n <= 1'b1;
      busy <= 3'h4;
    end else begin
      // Winner transfers briefly then idles; a stuck one never lets go
      cmd_n <= !(level != 4'hf && (stuck || busy != 3'h0));
      if (busy != 3'h0) busy <= busy - 3'h1;
    end
  end
endmodule

/* tb/cac_central_arbiter_tb.sv */
// Testbench: register access, arbitration timing, time-out and preempt
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module cac_central_arbiter_tb
  import cac_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic [3:0] lvl, win = 4'hf;
  logic cmd_n, floppy_dma_request = 0, nmi_rq = 0, c2m = 0, mclr = 0, rdone = 0, stuck = 0;
  logic arb_gnt, preempt_n, nmi, dma_reset, refresh_active, cpu_en, seen;
  int fail_count = 0, checks_done = 0, n;
  always #12.5 pclk = ~pclk;
  // Refresh done follows refresh_active by a cycle, so refresh lasts two cycles
  always @(posedge pclk) rdone <= refresh_active;
  cac_central_arbiter dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .priority_level_value(lvl), .cmd_n(cmd_n), .burst_n(1'b1),
    .floppy_dma_request(floppy_dma_request), .irq_active(1'b0), .nmi_request(nmi_rq),
    .chan2_masked(c2m), .dma_master_clear(mclr), .refresh_done(rdone), .arb_gnt(arb_gnt),
    .preempt_n(preempt_n), .nmi(nmi), .dma_reset(dma_reset),
    .refresh_active(refresh_active), .cpu_cycles_en(cpu_en));
  cac_masters far_u (.pclk(pclk), .presetn(presetn), .arb_gnt(arb_gnt), .win(win),
    .stuck(stuck), .level(lvl), .cmd_n(cmd_n));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic xfer(input logic [11:0] a, input logic w, input logic [7:0] d, input logic err);
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h0, d};
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    if (!w) `CHK("prdata", {24'h0, d}, prdata)
    `CHK("pslverr", err, pslverr)
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Counts arbitration time, leaving out refresh slots
  task automatic arb_len();
    n = 0;
    while (arb_gnt !== 1'b1) @(posedge pclk);
    while (arb_gnt === 1'b1) begin @(posedge pclk); n += int'(refresh_active !== 1'b1); end
    floppy_dma_request <= 1'b0;
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    wrap_up();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    xfer(ARB_CTRL_OFF, 1'b0, 8'h00, 1'b0);
    xfer(ARB_CTRL_OFF, 1'b1, 8'h90, 1'b0);
    xfer(12'h0a0, 1'b0, 8'h00, 1'b1);
    `CHK("cpu_en", 1'b1, cpu_en)
    nmi_rq <= 1'b1;
    repeat (4) @(posedge pclk);
    nmi_rq <= 1'b0;
    repeat (40) @(posedge pclk);
    `CHK("arb held", 1'b1, arb_gnt)
    xfer(ARB_CTRL_OFF, 1'b0, 8'hd0, 1'b0);
    xfer(ARB_CTRL_OFF, 1'b1, 8'hb0, 1'b0);
    repeat (40) @(posedge pclk);
    `CHK("arb freed", 1'b0, arb_gnt)
    xfer(ARB_CTRL_OFF, 1'b0, 8'h90, 1'b0);
    win <= LVL_FLOPPY;
    floppy_dma_request <= 1'b1;
    arb_len();
    `CHK("ext len", 1'b1, n >= ARB_EXT_CYC - 1 && n <= ARB_EXT_CYC + 1)
    win <= LVL_SYSTEM;
    repeat (80) @(posedge pclk);
    `CHK("floppy won", 1'b1, preempt_n)
    xfer(ARB_CTRL_OFF, 1'b1, 8'h00, 1'b0);
    for (int i = 0; i < 2; i++) begin
      win <= i ? LVL_ZERO : LVL_SYSTEM;
      floppy_dma_request <= 1'b1;
      arb_len();
      if (i) `CHK("zero len", 1'b1, n >= ARB_MIN_CYC - 1 && n < ARB_NORM_CYC - 1)
      else `CHK("norm len", 1'b1, n >= ARB_NORM_CYC - 1 && n <= ARB_NORM_CYC + 1)
      win <= LVL_SYSTEM;
      mclr <= 1'b1;
      @(posedge pclk);
      mclr <= 1'b0;
      repeat (60) @(posedge pclk);
      `CHK("master clear", 1'b1, preempt_n)
    end
    c2m <= 1'b1;
    floppy_dma_request <= 1'b1;
    repeat (8) @(posedge pclk);
    `CHK("masked", 1'b1, preempt_n)
    c2m <= 1'b0;
    win <= 4'h3;
    stuck <= 1'b1;
    floppy_dma_request <= 1'b0;
    repeat (4) @(posedge pclk);
    floppy_dma_request <= 1'b1;
    seen = 1'b0;
    while (nmi !== 1'b1) begin @(posedge pclk); seen |= (dma_reset === 1'b1); end
    @(posedge pclk);
    `CHK("dma reset", 1'b1, seen | dma_reset)
    stuck <= 1'b0;
    repeat (50) @(posedge pclk);
    xfer(ARB_CTRL_OFF, 1'b0, 8'h63, 1'b0);
    xfer(ARB_CTRL_OFF, 1'b1, 8'h00, 1'b0);
    `CHK("nmi clear", 1'b0, nmi)
    wrap_up();
  end
endmodule
